// ===== rtl/bpc_pkg.sv
/*
 * Shared constants of the BERT pattern control block: register indices and
 * byte addresses, field positions, values after reset, pattern taps and
 * lock thresholds.
 * Assumes a 32-bit AXI4-Lite register bus with 12-bit byte addresses.
 */
package bpc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Bus widths and responses.
    localparam int AXI_ADDR_W = 12;
    localparam int AXI_DATA_W = 32;
    localparam int AXI_STRB_W = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // Register indices; each register takes one word at four times its index.
    localparam logic [11:0] CSR1_INDEX = 12'h123;
    localparam logic [11:0] SWITCH_INDEX = 12'h121;
    localparam logic [11:0] CSR1_ADDR = CSR1_INDEX << 2;
    localparam logic [11:0] SWITCH_ADDR = SWITCH_INDEX << 2;

    ////////////////////////////////////////////////////////////////////////
    // Field positions inside bert_control_status_one.
    localparam int PATTERN_TYPE_BIT = 7;
    localparam int ERR_INJECT_BIT = 6;
    localparam int DATA_INVERT_BIT = 5;
    localparam int LOCK_BIT = 4;
    localparam int DET_ENABLE_BIT = 3;
    localparam int GEN_ENABLE_BIT = 2;
    // Field position of the pattern switch inside the switch register.
    localparam int SWITCH_BIT = 3;

    // Values after reset and the bits that software may write.
    localparam logic [7:0] CSR1_RESET = 8'h00;
    localparam logic [7:0] CSR1_WRITE_MASK = 8'hec;
    localparam logic [7:0] SWITCH_RESET = 8'h00;
    localparam logic [7:0] SWITCH_WRITE_MASK = 8'h08;

    ////////////////////////////////////////////////////////////////////////
    // Pattern shift register: PRBS15 taps 15 and 14, QRTS taps 20 and 17.
    localparam int LFSR_W = 20;
    localparam logic [19:0] LFSR_SEED = 20'hfffff;
    localparam int PRBS15_TAP_A = 14;
    localparam int PRBS15_TAP_B = 13;
    localparam int QRTS_TAP_A = 19;
    localparam int QRTS_TAP_B = 16;
    localparam int QRTS_ZERO_RUN = 14;

    // Lock is declared after this many matches in a row, lost after errors.
    localparam logic [5:0] LOCK_MATCHES = 6'h20;
    localparam logic [2:0] UNLOCK_ERRORS = 3'h4;

endpackage : bpc_pkg

// ===== rtl/bpc_lfsr.sv
/*
 * Pattern shift register shared by the generator and the checker. It runs
 * either PRBS15 or QRTS; in checker use the received bit is shifted in so
 * that it synchronises itself to the incoming stream.
 * Assumes step and load signals come from logic on the same clock.
 */
`timescale 1ns/1ns
module bpc_lfsr
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic step,
    input wire logic qrts_mode,
    input wire logic load_en,
    input wire logic load_bit,
    output logic out_bit
);
    import bpc_pkg::*;

    logic [LFSR_W-1:0] state_q;
    logic [LFSR_W-1:0] state_d;
    logic feedback;

    ////////////////////////////////////////////////////////////////////////
    // Feedback of the selected polynomial; QRTS forces a one after a long
    // run of zeros so the line never sees excess zeros.
    always_comb
    begin
        if (qrts_mode)
        begin
            feedback = state_q[QRTS_TAP_A] ^ state_q[QRTS_TAP_B];
            out_bit = feedback | (state_q[QRTS_ZERO_RUN-1:0] == '0);
        end
        else
        begin
            feedback = state_q[PRBS15_TAP_A] ^ state_q[PRBS15_TAP_B]; // RULE_02
            out_bit = feedback;
        end
        state_d = {state_q[LFSR_W-2:0], load_en ? load_bit : feedback};
    end

    // The state only moves on a step, so a stopped generator holds still.
    always_ff @(posedge core_clk)
    begin
        if (srst)
            state_q <= LFSR_SEED;
        else if (ce && step)
            state_q <= state_d;
    end

    AST_PRBS15_TAPS: assert property (@(posedge core_clk) disable iff (srst)
        (ce && step && !qrts_mode && !load_en) |=>
        state_q[0] == ($past(state_q[14]) ^ $past(state_q[13]))) // RULE_02
        else $error("PRBS15 feedback is not x15 + x14 + 1.");

endmodule : bpc_lfsr

// ===== rtl/bpc_lock_monitor.sv
/*
 * Lock monitor of the pattern checker: declares lock after a run of
 * matching bits and drops it after repeated mismatches.
 * Assumes sample and match come from logic on the same clock.
 */
`timescale 1ns/1ns
module bpc_lock_monitor
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic enable,
    input wire logic sample,
    input wire logic match,
    output logic lock_q
);
    import bpc_pkg::*;

    logic [5:0] match_cnt_q;
    logic [2:0] err_cnt_q;

    ////////////////////////////////////////////////////////////////////////
    // A single inserted error must not drop lock, so errors are counted and
    // the count is forgiven by a full run of good bits.
    always_ff @(posedge core_clk)
    begin
        if (srst || (ce && !enable))
        begin
            match_cnt_q <= '0;
            err_cnt_q <= '0;
            lock_q <= 1'b0;
        end
        else if (ce && sample)
        begin
            if (match)
            begin
                if (match_cnt_q == LOCK_MATCHES - 6'h1)
                begin
                    lock_q <= 1'b1;
                    err_cnt_q <= '0;
                end
                if (match_cnt_q != LOCK_MATCHES)
                    match_cnt_q <= match_cnt_q + 6'h1;
            end
            else
            begin
                match_cnt_q <= '0;
                if (err_cnt_q == UNLOCK_ERRORS - 3'h1)
                begin
                    lock_q <= 1'b0;
                    err_cnt_q <= '0;
                end
                else
                    err_cnt_q <= err_cnt_q + 3'h1;
            end
        end
    end

endmodule : bpc_lock_monitor

// ===== rtl/bpc_bert_control.sv
/*
 * Control part of the bit-error-rate tester: pattern type, single error
 * insertion, data inversion and the switch that picks which framer
 * generates and which checks. Registers sit behind an AXI4-Lite slave.
 * Assumes the framer bit strobes and serial data come from logic on
 * core_clk, one bit per strobe.
 */
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns

// Function
// RULE_01: Pattern-type bit picks the sequence for both generator and checker.
// RULE_02: Type 0 gives PRBS15 x15+x14+1; type 1 gives the QRTS pattern.
// RULE_03: Switch cleared: transmit side generates the pattern toward the line.
// RULE_04: Switch set: receive side generates toward the receive backplane.
// RULE_05: Each rising edge of error insertion flips exactly one output bit.
// RULE_06: Error insertion acts only while generation is enabled.
// RULE_07: Switch cleared: the inserted error appears on the line output.
// RULE_08: Switch set: the inserted error appears on the backplane output.
// RULE_09: Invert, switch cleared: invert line output and checked line input.
// RULE_10: Invert, switch set: invert backplane output and checked tx input.
// RULE_11: Invert cleared leaves both paths unchanged; set inverts both.
// RULE_12: Generator runs only while generation enable bit 2 is set.
// RULE_13: Checking runs only while detection enable bit 3 is set.
// RULE_14: Error edge found against last cycle's value, one-cycle strobe.
module bpc_bert_control
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [bpc_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [bpc_pkg::AXI_DATA_W-1:0] s_axi_wdata,
    input wire logic [bpc_pkg::AXI_STRB_W-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [bpc_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [bpc_pkg::AXI_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic gen_bit_strobe,
    output logic line_test_bit,
    output logic line_test_valid,
    output logic backplane_test_bit,
    output logic backplane_test_valid,
    input wire logic line_rx_bit,
    input wire logic line_rx_valid,
    input wire logic tx_backplane_bit,
    input wire logic tx_backplane_valid,
    output logic pattern_switch,
    output logic pattern_generator_enable,
    output logic pattern_detector_enable,
    output logic test_lock
);
    import bpc_pkg::*;

    logic [7:0] csr1_q, switch_reg_q, csr1_read;
    logic [AXI_ADDR_W-1:0] aw_addr_q, wr_addr;
    logic [AXI_DATA_W-1:0] w_data_q, rdata_q, wr_data;
    logic [AXI_STRB_W-1:0] w_strb_q, wr_strb;
    logic [1:0] bresp_q, rresp_q;
    logic aw_held_q, w_held_q, bvalid_q, rvalid_q;
    logic aw_fire, w_fire, do_write, qrts_mode, invert;
    logic inj_prev_q, inj_rise, inj_pending_q, gen_step, gen_raw, gen_bit;
    logic line_bit_q, line_valid_q, bp_bit_q, bp_valid_q;
    logic chk_valid, chk_in, chk_pred;

    ////////////////////////////////////////////////////////////////////////
    // Control fields steer the pattern logic directly.
    assign qrts_mode = csr1_q[PATTERN_TYPE_BIT]; // RULE_01
    assign invert = csr1_q[DATA_INVERT_BIT];
    assign pattern_switch = switch_reg_q[SWITCH_BIT];
    assign pattern_generator_enable = csr1_q[GEN_ENABLE_BIT];
    assign pattern_detector_enable = csr1_q[DET_ENABLE_BIT];
    assign csr1_read = csr1_q | {3'h0, test_lock, 4'h0};

    ////////////////////////////////////////////////////////////////////////
    // Write channels are taken in either order; each is held until the
    // other arrives, and no new one is taken while a response waits.
    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready = !w_held_q && !bvalid_q;
    assign aw_fire = s_axi_awvalid && s_axi_awready;
    assign w_fire = s_axi_wvalid && s_axi_wready;
    assign do_write = ce && (aw_held_q || aw_fire) && (w_held_q || w_fire);
    assign wr_addr = aw_held_q ? aw_addr_q : s_axi_awaddr;
    assign wr_data = w_held_q ? w_data_q : s_axi_wdata;
    assign wr_strb = w_held_q ? w_strb_q : s_axi_wstrb;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // Write address and data holding stage.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end
        else if (ce)
        begin
            aw_held_q <= (aw_held_q || aw_fire) && !do_write;
            w_held_q <= (w_held_q || w_fire) && !do_write;
            if (aw_fire)
                aw_addr_q <= s_axi_awaddr;
            if (w_fire)
            begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
        end
    end

    // Write response; an unmapped address answers with a slave error.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end
        else if (ce)
        begin
            if (do_write)
            begin
                bvalid_q <= 1'b1;
                if (wr_addr == CSR1_ADDR || wr_addr == SWITCH_ADDR)
                    bresp_q <= RESP_OKAY;
                else
                    bresp_q <= RESP_SLVERR;
            end
            else if (s_axi_bready)
                bvalid_q <= 1'b0;
        end
    end

    // Register stores; only byte lane 0 carries data, read-only and
    // left-out bits are masked off.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            csr1_q <= CSR1_RESET;
            switch_reg_q <= SWITCH_RESET;
        end
        else if (do_write && wr_strb[0])
        begin
            if (wr_addr == CSR1_ADDR)
                csr1_q <= wr_data[7:0] & CSR1_WRITE_MASK;
            else if (wr_addr == SWITCH_ADDR)
                switch_reg_q <= wr_data[7:0] & SWITCH_WRITE_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel answers one cycle after the address is taken.
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= '0;
        end
        else if (ce)
        begin
            if (s_axi_arvalid && !rvalid_q)
            begin
                rvalid_q <= 1'b1;
                rresp_q <= RESP_OKAY;
                if (s_axi_araddr == CSR1_ADDR)
                    rdata_q <= {24'h0, csr1_read};
                else if (s_axi_araddr == SWITCH_ADDR)
                    rdata_q <= {24'h0, switch_reg_q};
                else
                begin
                    rdata_q <= '0;
                    rresp_q <= RESP_SLVERR;
                end
            end
            else if (s_axi_rready)
                rvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Error insertion edge: a steady level does nothing, and an edge while
    // the generator is stopped is dropped rather than saved for later.
    assign inj_rise = csr1_q[ERR_INJECT_BIT] && !inj_prev_q
        && pattern_generator_enable; // RULE_14 RULE_06

    always_ff @(posedge core_clk)
    begin
        if (srst)
            inj_prev_q <= 1'b0;
        else if (ce)
            inj_prev_q <= csr1_q[ERR_INJECT_BIT]; // RULE_14
    end

    // The pending error is set by the strobe and spent on the next bit;
    // the set wins over the spend so back-to-back edges are not lost.
    always_ff @(posedge core_clk)
    begin
        if (srst)
            inj_pending_q <= 1'b0;
        else if (ce)
        begin
            if (!pattern_generator_enable)
                inj_pending_q <= 1'b0; // RULE_06
            else if (inj_rise)
                inj_pending_q <= 1'b1; // RULE_05
            else if (gen_step)
                inj_pending_q <= 1'b0; // RULE_05
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Generator: steps on each framer bit strobe while enabled.
    assign gen_step = ce && pattern_generator_enable && gen_bit_strobe; // RULE_12
    assign gen_bit = gen_raw ^ invert ^ inj_pending_q; // RULE_11 RULE_05

    bpc_lfsr u_gen_lfsr
    (
        .core_clk(core_clk),
        .srst(srst),
        .ce(ce),
        .step(pattern_generator_enable && gen_bit_strobe),
        .qrts_mode(qrts_mode),
        .load_en(1'b0),
        .load_bit(1'b0),
        .out_bit(gen_raw)
    );

    // The switch decides which framer output carries the pattern.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            line_bit_q <= 1'b0;
            line_valid_q <= 1'b0;
            bp_bit_q <= 1'b0;
            bp_valid_q <= 1'b0;
        end
        else if (ce)
        begin
            line_valid_q <= gen_step && !pattern_switch; // RULE_03
            bp_valid_q <= gen_step && pattern_switch; // RULE_04
            if (gen_step && !pattern_switch)
                line_bit_q <= gen_bit; // RULE_07 RULE_09
            if (gen_step && pattern_switch)
                bp_bit_q <= gen_bit; // RULE_08 RULE_10
        end
    end

    assign line_test_bit = line_bit_q;
    assign line_test_valid = line_valid_q;
    assign backplane_test_bit = bp_bit_q;
    assign backplane_test_valid = bp_valid_q;

    ////////////////////////////////////////////////////////////////////////
    // Checker: line receive data normally, transmit backplane data when
    // switched; inversion is undone before comparing.
    assign chk_valid = pattern_switch ? tx_backplane_valid
        : line_rx_valid; // RULE_13
    assign chk_in = (pattern_switch ? tx_backplane_bit : line_rx_bit)
        ^ invert; // RULE_09 RULE_10

    // QRTS zero suppression is not undone here, so long zero runs cost a
    // few mismatches; the error counter in the lock monitor absorbs them.
    bpc_lfsr u_chk_lfsr
    (
        .core_clk(core_clk),
        .srst(srst),
        .ce(ce),
        .step(pattern_detector_enable && chk_valid),
        .qrts_mode(qrts_mode),
        .load_en(1'b1),
        .load_bit(chk_in),
        .out_bit(chk_pred)
    );

    bpc_lock_monitor u_lock
    (
        .core_clk(core_clk),
        .srst(srst),
        .ce(ce),
        .enable(pattern_detector_enable),
        .sample(chk_valid),
        .match(chk_in == chk_pred),
        .lock_q(test_lock)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks on the pattern path and the write response.
    AST_LINE_ONLY_UNSWITCHED: assert property (@(posedge core_clk) // RULE_03
        disable iff (srst)
        (line_test_valid && $past(ce)) |-> $past(!pattern_switch
            && gen_bit_strobe && pattern_generator_enable))
        else $error("Line pattern sent while switched or stopped.");

    AST_BACKPLANE_ONLY_SWITCHED: assert property (@(posedge core_clk) // RULE_04
        disable iff (srst)
        (ce && gen_step && pattern_switch) |=>
        backplane_test_valid && !line_test_valid)
        else $error("Switched pattern did not reach the backplane.");

    AST_INJECT_STROBE: assert property (@(posedge core_clk) // RULE_14
        disable iff (srst)
        (ce && csr1_q[ERR_INJECT_BIT] && !inj_prev_q
            && pattern_generator_enable) |=> inj_pending_q)
        else $error("Error insertion edge was not armed.");

    AST_INJECT_LEVEL_QUIET: assert property (@(posedge core_clk) // RULE_05
        disable iff (srst)
        (ce && gen_step && !inj_rise) |=> !inj_pending_q)
        else $error("Pending error survived the bit it corrupted.");

    AST_INJECT_GATED: assert property (@(posedge core_clk) // RULE_06
        disable iff (srst)
        (ce && !pattern_generator_enable) |=> !inj_pending_q)
        else $error("Error armed while the generator is off.");

    AST_OUTPUT_BIT: assert property (@(posedge core_clk) // RULE_11
        disable iff (srst)
        (ce && gen_step && !pattern_switch) |=> line_test_bit ==
        ($past(gen_raw) ^ $past(invert) ^ $past(inj_pending_q)))
        else $error("Line bit is not pattern xor invert xor error.");

    AST_GEN_STOPPED: assert property (@(posedge core_clk) // RULE_12
        disable iff (srst)
        (ce && !pattern_generator_enable) [*2] |->
        !line_test_valid && !backplane_test_valid)
        else $error("Pattern output while generation is disabled.");

    AST_DET_OFF_NO_LOCK: assert property (@(posedge core_clk) // RULE_13
        disable iff (srst)
        (ce && !pattern_detector_enable) |=> !test_lock)
        else $error("Lock shown while detection is disabled.");

    AST_CHECK_INVERT: assert property (@(posedge core_clk) // RULE_10
        disable iff (srst)
        (pattern_switch && invert) |-> chk_in == !tx_backplane_bit)
        else $error("Switched checker input is not inverted.");

    AST_BRESP_HELD: assert property (@(posedge core_clk)
        disable iff (srst)
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("Write response dropped before it was taken.");

endmodule : bpc_bert_control

// ===== testbench/bpc_far_end.sv
/*
 * Far-side model: framer bit timing and a loopback of both test streams.
 * Assumes every signal is on core_clk.
 */
`timescale 1ns/1ns
module bpc_far_end
(
    input wire logic core_clk,
    input wire logic line_test_bit,
    input wire logic line_test_valid,
    input wire logic backplane_test_bit,
    input wire logic backplane_test_valid,
    output logic gen_bit_strobe = 1'b0,
    output logic line_rx_bit = 1'b0,
    output logic line_rx_valid = 1'b0,
    output logic tx_backplane_bit = 1'b0,
    output logic tx_backplane_valid = 1'b0
);
    logic [1:0] div_q = 2'h0;
    ////////////////////////////////////////////////////////////
    // One bit time in four clocks; idle data lines toggle so that a
    // stale bit is never taken for a fresh one.
    always_ff @(posedge core_clk)
    begin
        div_q <= div_q + 2'h1;
        gen_bit_strobe <= (div_q == 2'h0);
        line_rx_valid <= line_test_valid;
        line_rx_bit <= line_test_valid ? line_test_bit : ~line_rx_bit;
        tx_backplane_valid <= backplane_test_valid;
        tx_backplane_bit <= backplane_test_valid ? backplane_test_bit
            : ~tx_backplane_bit;
    end
endmodule : bpc_far_end

// ===== testbench/bert_pattern_control_test.sv
/*
 * Self-checking bench of the BERT pattern control block.
 * Assumes the far-end model loops both test streams back.
 */
`timescale 1ns/1ns
module bert_pattern_control_test;
    import bpc_pkg::*;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rnd;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, line_test_bit, line_test_valid, backplane_test_bit;
    logic backplane_test_valid, pattern_switch, pattern_generator_enable;
    logic pattern_detector_enable, test_lock, gen_bit_strobe, cur;
    logic line_rx_bit, line_rx_valid, tx_backplane_bit, tx_backplane_valid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [14:0] hist = 15'h0;
    logic [33:0] exp_q[$];
    logic [33:0] exp_r;
    logic inv_exp = 1'b0;
    int n_errors = 0, checked = 0, viol = 0, n_bits = 0, line_cnt = 0;
    int v0, c0;

    bpc_bert_control u_dut (.core_clk, .srst, .ce(1'b1), .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .gen_bit_strobe, .line_test_bit, .line_test_valid,
        .backplane_test_bit, .backplane_test_valid, .line_rx_bit,
        .line_rx_valid, .tx_backplane_bit, .tx_backplane_valid,
        .pattern_switch, .pattern_generator_enable, .pattern_detector_enable,
        .test_lock);
    bpc_far_end u_far (.core_clk, .line_test_bit, .line_test_valid,
        .backplane_test_bit, .backplane_test_valid, .gen_bit_strobe,
        .line_rx_bit, .line_rx_valid, .tx_backplane_bit, .tx_backplane_valid);

    ////////////////////////////////////////////////////////////
    // Clock of 20 ns.
    always #10 core_clk = ~core_clk;

    task automatic finish_test;
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : finish_test

    task automatic stall;
        n_errors++;
        finish_test();
    endtask : stall

    task automatic cmp(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp

    // A write holds each channel until taken, then waits for the answer.
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
        input logic [1:0] er);
        int n;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid)
                break;
        end
        s_axi_bready <= 1'b0;
        if (n == 50)
            stall();
        cmp("bresp", er, s_axi_bresp);
    endtask : axi_wr

    // A read notes its expected answer; the watcher compares it.
    task automatic axi_rd(input logic [11:0] a, input logic [33:0] e);
        int n;
        @(posedge core_clk);
        exp_q.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
                break;
        end
        s_axi_rready <= 1'b0;
        if (n == 50)
            stall();
    endtask : axi_rd

    task automatic run_bits(input int k);
        int t;
        t = n_bits + k;
        for (int c = 0; c < 400; c++)
        begin
            @(posedge core_clk);
            if (n_bits >= t)
                return;
        end
        stall();
    endtask : run_bits

    ////////////////////////////////////////////////////////////
    // Read watcher; an empty queue pops an unknown and so mismatches.
    always @(posedge core_clk)
        if (s_axi_rvalid && s_axi_rready)
        begin
            exp_r = exp_q.pop_front();
            cmp("rdata", exp_r[31:0], s_axi_rdata);
            cmp("rresp", {30'h0, exp_r[33:32]}, {30'h0, s_axi_rresp});
        end

    // Counts breaks of b[n] = b[n-14] ^ b[n-15] after undoing inversion.
    always @(negedge core_clk)
        if (line_test_valid || backplane_test_valid)
        begin
            cur = (line_test_valid ? line_test_bit : backplane_test_bit)
                ^ inv_exp;
            if (n_bits >= 15 && cur !== (hist[13] ^ hist[14]))
                viol++;
            hist = {hist[13:0], cur};
            n_bits++;
            if (line_test_valid)
                line_cnt++;
        end

    ////////////////////////////////////////////////////////////
    // Main sequence; every settle of 20 bits flushes stale history.
    initial
    begin
        void'($urandom(68));
        rnd = $urandom;
        repeat (6) @(posedge core_clk);
        srst <= 1'b0;
        axi_rd(CSR1_ADDR, {RESP_OKAY, 32'h0});
        axi_rd(SWITCH_ADDR, {RESP_OKAY, 32'h0});
        axi_rd(12'h000, {RESP_SLVERR, 32'h0});
        axi_wr(12'h000, rnd, RESP_SLVERR);
        axi_wr(CSR1_ADDR, {rnd[31:8], 8'hff}, RESP_OKAY);
        axi_rd(CSR1_ADDR, {RESP_OKAY, 32'hec});
        axi_wr(CSR1_ADDR, 32'h0, RESP_OKAY);
        c0 = line_cnt;
        repeat (40) @(posedge core_clk);
        cmp("bits while off", c0, line_cnt);
        for (int i = 0; i < 2; i++)
        begin
            inv_exp = i[0];
            axi_wr(CSR1_ADDR, {rnd[31:8], 2'h0, i[0], 5'h0c}, RESP_OKAY);
            run_bits(20);
            v0 = viol;
            run_bits(40);
            cmp("breaks", 0, viol - v0);
        end
        cmp("lock", 1, test_lock);
        cmp("gen enable", 1, pattern_generator_enable);
        for (int s = 0; s < 2; s++)
        begin
            axi_wr(SWITCH_ADDR, {rnd[31:4], s[0], 3'h0}, RESP_OKAY);
            run_bits(20);
            v0 = viol;
            c0 = line_cnt;
            axi_wr(CSR1_ADDR, 32'h6c, RESP_OKAY);
            axi_wr(CSR1_ADDR, 32'h2c, RESP_OKAY);
            run_bits(40);
            cmp("inserted breaks", 3, viol - v0);
            cmp("line used", !s[0], line_cnt != c0);
            cmp("switch", s[0], pattern_switch);
        end
        run_bits(40);
        axi_rd(CSR1_ADDR, {RESP_OKAY, 32'h3c});
        axi_wr(SWITCH_ADDR, 32'h0, RESP_OKAY);
        run_bits(20);
        axi_wr(CSR1_ADDR, 32'h28, RESP_OKAY);
        axi_wr(CSR1_ADDR, 32'h68, RESP_OKAY);
        v0 = viol;
        axi_wr(CSR1_ADDR, 32'h6c, RESP_OKAY);
        run_bits(40);
        cmp("breaks", 0, viol - v0);
        axi_wr(CSR1_ADDR, 32'hac, RESP_OKAY);
        run_bits(20);
        v0 = viol;
        run_bits(40);
        cmp("pattern differs", 1, viol != v0);
        axi_wr(CSR1_ADDR, 32'h0, RESP_OKAY);
        repeat (3) @(posedge core_clk);
        cmp("lock", 0, test_lock);
        cmp("det enable", 0, pattern_detector_enable);
        finish_test();
    end
endmodule : bert_pattern_control_test
